/* core/lda_regs.svh */
// Purpose: offsets, field positions and reset values of the locality decoder
// Assumes: 16-bit offset per host cycle, locality in the top nibble
// Notes:   hash offsets are relative to the locality-4 window
`ifndef LDA_REGS_SVH
`define LDA_REGS_SVH
`define LDA_LOC_MSB 15
`define LDA_LOC_LSB 12
`define LDA_LOC_TOP 4'h4
`define LDA_OFF_LOC4_CTRL 12'h008
`define LDA_OFF_HASH_END 12'h020
`define LDA_OFF_HASH_DATA 12'h024
`define LDA_OFF_HASH_START 12'h028
`define LDA_OFF_CMD_BUF 12'h080
`define LDA_CTRL_BEGIN_BIT 0
`define LDA_CTRL_END_BIT 1
`define LDA_RST_OWNER 3'h0
`define LDA_RST_IND 5'h00
`endif

/* core/lda_pkg.sv */
// Purpose: types shared by the locality decoder
// Assumes: nothing
// Notes:   none
package lda_pkg;
    typedef enum logic [1:0] {ST_FREE, ST_OWNED, ST_HASH} lda_state_t;
    typedef enum logic [1:0] {CMD_NONE, CMD_BEGIN, CMD_DATA, CMD_END} lda_cmd_t;
endpackage

/* core/lda_arbiter.sv */
// Purpose: locality decode, ownership arbitration and hash command gating
// Assumes: host offers each cycle for one link clock, then waits for o_link_wait to drop; requests are levels
// Notes:   one host cycle in flight across the clock crossing at a time
// Behaviour
// - locality comes from offset bits 15:12
// - localities reported as one-hot indicators
// - highest requesting locality wins ownership
// - free state accepts hash command writes
// - hash begin ignored under other owner
// - hash begin with no owner takes locality 4
// - hash end frees locality 4
// - six states: none and localities 0-4
// - protected resources checked against access locality
// - during hash only hash writes other than hash begin pass
`include "lda_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module lda_arbiter
(
    // clocks and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_link_clk,
    // host cycle on the link clock
    input  wire logic       i_cyc_valid,
    input  wire logic       i_cyc_write,
    input  wire logic [15:0] i_cyc_addr,
    input  wire logic [7:0] i_cyc_data,
    output var  logic       o_link_wait,
    // map select and ownership requests
    input  wire logic       i_buffer_map,
    input  wire logic [4:0] i_req,
    input  wire logic [4:0] i_seize,
    input  wire logic       i_relinquish,
    // protected resource check
    input  wire logic       i_chk_valid,
    input  wire logic [4:0] i_chk_mask,
    output var  logic       o_chk_done,
    output var  logic       o_chk_ok,
    // results
    output var  logic [4:0] o_active_ind,
    output var  logic       o_hash_active,
    output var  logic       o_acc_valid,
    output var  logic       o_acc_ok,
    output var  logic [4:0] o_acc_ind,
    output var  logic       o_hash_start,
    output var  logic       o_hash_data,
    output var  logic       o_hash_end,
    output var  logic [7:0] o_hash_byte
);

    function automatic logic [2:0] hi_idx(input logic [4:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < 5; k++)
        begin
            if (v[k])
            begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] ind_of(input logic [2:0] idx);
        return 5'(5'h01 << idx);
    endfunction

    function automatic logic [4:0] above(input logic [2:0] idx);
        return 5'(5'h1E << idx);
    endfunction

    // link domain: capture and hold one cycle until the core acknowledges
    logic        l_busy;
    logic        l_tgl;
    logic [24:0] l_word;
    logic        l_ack_s1;
    logic        l_ack_s2;
    logic        next_l_busy;
    logic        next_l_tgl;
    logic [24:0] next_l_word;
    logic        l_take;
    logic        c_ack;

    always_comb
    begin
        l_take      = i_cyc_valid & ~l_busy;
        next_l_tgl  = l_tgl ^ l_take;
        next_l_word = l_take ? {i_cyc_write, i_cyc_addr, i_cyc_data} : l_word;
        next_l_busy = l_take | (l_busy & (l_ack_s2 != l_tgl));
    end

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            l_busy   <= 1'b0;
            l_tgl    <= 1'b0;
            l_word   <= 25'h0000000;
            l_ack_s1 <= 1'b0;
            l_ack_s2 <= 1'b0;
        end
        else
        begin
            l_busy   <= next_l_busy;
            l_tgl    <= next_l_tgl;
            l_word   <= next_l_word;
            l_ack_s1 <= c_ack;
            l_ack_s2 <= l_ack_s1;
        end
    end

    assign o_link_wait = l_busy;

    // core domain: toggle synchroniser, word is stable while the toggle differs
    logic c_s1;
    logic c_s2;
    logic c_s3;
    logic new_cyc;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            c_s1  <= 1'b0;
            c_s2  <= 1'b0;
            c_s3  <= 1'b0;
            c_ack <= 1'b0;
        end
        else
        begin
            c_s1  <= l_tgl;
            c_s2  <= c_s1;
            c_s3  <= c_s2;
            c_ack <= c_ack ^ new_cyc;
        end
    end

    assign new_cyc = c_s2 ^ c_s3;

    // decode of the held cycle
    logic              w_write;
    logic [3:0]        w_nib;
    logic [11:0]       w_off;
    logic              loc_ok;
    logic [2:0]        w_loc;
    logic              top_ctrl;
    logic              hash_path;
    lda_pkg::lda_cmd_t cmd;

    always_comb
    begin
        w_write  = l_word[24];
        w_nib    = l_word[`LDA_LOC_MSB + 8:`LDA_LOC_LSB + 8];
        w_off    = l_word[19:8];
        loc_ok   = w_nib <= `LDA_LOC_TOP;
        w_loc    = w_nib[2:0];
        top_ctrl = i_buffer_map && w_off == `LDA_OFF_LOC4_CTRL;
        cmd      = lda_pkg::CMD_NONE;
        if (w_write && w_nib == `LDA_LOC_TOP)
        begin
            if (!i_buffer_map)
            begin
                case (w_off)
                    `LDA_OFF_HASH_START: cmd = lda_pkg::CMD_BEGIN;
                    `LDA_OFF_HASH_DATA:  cmd = lda_pkg::CMD_DATA;
                    `LDA_OFF_HASH_END:   cmd = lda_pkg::CMD_END;
                    default:             cmd = lda_pkg::CMD_NONE;
                endcase
            end
            else if (top_ctrl)
            begin
                if (l_word[`LDA_CTRL_BEGIN_BIT])
                begin
                    cmd = lda_pkg::CMD_BEGIN;
                end
                else if (l_word[`LDA_CTRL_END_BIT])
                begin
                    cmd = lda_pkg::CMD_END;
                end
            end
            else if (w_off == `LDA_OFF_CMD_BUF)
            begin
                cmd = lda_pkg::CMD_DATA;
            end
        end
        hash_path = cmd != lda_pkg::CMD_NONE || (w_write && w_nib == `LDA_LOC_TOP && top_ctrl);
    end

    // ownership state: none, or one of localities 0-4
    lda_pkg::lda_state_t st;
    lda_pkg::lda_state_t next_st;
    logic [2:0]          owner;
    logic [2:0]          next_owner;
    logic [4:0]          cmd_ind;
    logic [4:0]          next_cmd_ind;
    logic                acc_ok;
    logic                hs;
    logic                hd;
    logic                he;
    logic [4:0]          seize_eff;
    logic [4:0]          pend;

    always_comb
    begin
        next_st      = st;
        next_owner   = owner;
        next_cmd_ind = cmd_ind;
        acc_ok       = 1'b0;
        hs           = 1'b0;
        hd           = 1'b0;
        he           = 1'b0;
        seize_eff    = i_seize & above(owner);
        pend         = i_req & ~ind_of(owner);
        if (new_cyc)
        begin
            case (st)
                lda_pkg::ST_FREE:
                begin
                    acc_ok = hash_path;
                    if (cmd == lda_pkg::CMD_BEGIN)
                    begin
                        next_st    = lda_pkg::ST_HASH;
                        next_owner = 3'h4;
                        hs         = 1'b1;
                    end
                end
                lda_pkg::ST_OWNED:
                begin
                    acc_ok = loc_ok && !hash_path && w_loc == owner;
                    if (cmd == lda_pkg::CMD_BEGIN && owner == 3'h4)
                    begin
                        acc_ok  = 1'b1;
                        next_st = lda_pkg::ST_HASH;
                        hs      = 1'b1;
                    end
                    // other owner: begin dropped
                end
                lda_pkg::ST_HASH:
                begin
                    acc_ok = hash_path && cmd != lda_pkg::CMD_BEGIN;
                    if (acc_ok && cmd == lda_pkg::CMD_DATA)
                    begin
                        hd = 1'b1;
                    end
                    if (acc_ok && cmd == lda_pkg::CMD_END)
                    begin
                        he         = 1'b1;
                        next_st    = lda_pkg::ST_FREE;
                        next_owner = `LDA_RST_OWNER;
                    end
                end
                default:
                begin
                    next_st = lda_pkg::ST_FREE;
                end
            endcase
            if (acc_ok)
            begin
                next_cmd_ind = ind_of(w_loc);
            end
        end
        else
        begin
            // arbitration waits for clocks with no new host cycle
            case (st)
                lda_pkg::ST_FREE:
                begin
                    if (|i_req)
                    begin
                        next_st    = lda_pkg::ST_OWNED;
                        next_owner = hi_idx(i_req);
                    end
                end
                lda_pkg::ST_OWNED:
                begin
                    if (|seize_eff)
                    begin
                        next_owner = hi_idx(seize_eff);
                    end
                    else if (i_relinquish)
                    begin
                        next_st    = (|pend) ? lda_pkg::ST_OWNED : lda_pkg::ST_FREE;
                        next_owner = (|pend) ? hi_idx(pend) : `LDA_RST_OWNER;
                    end
                end
                default:
                begin
                    next_st = st;
                end
            endcase
        end
    end

    // registered outputs
    logic [4:0] next_active;
    logic       next_chk_ok;

    always_comb
    begin
        next_active = (next_st == lda_pkg::ST_FREE) ? `LDA_RST_IND : ind_of(next_owner);
        next_chk_ok = i_chk_valid && |(i_chk_mask & cmd_ind);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st            <= lda_pkg::ST_FREE;
            owner         <= `LDA_RST_OWNER;
            cmd_ind       <= `LDA_RST_IND;
            o_active_ind  <= `LDA_RST_IND;
            o_hash_active <= 1'b0;
            o_acc_valid   <= 1'b0;
            o_acc_ok      <= 1'b0;
            o_acc_ind     <= `LDA_RST_IND;
            o_hash_start  <= 1'b0;
            o_hash_data   <= 1'b0;
            o_hash_end    <= 1'b0;
            o_hash_byte   <= 8'h00;
            o_chk_done    <= 1'b0;
            o_chk_ok      <= 1'b0;
        end
        else
        begin
            st            <= next_st;
            owner         <= next_owner;
            cmd_ind       <= next_cmd_ind;
            o_active_ind  <= next_active;
            o_hash_active <= next_st == lda_pkg::ST_HASH;
            o_acc_valid   <= new_cyc;
            o_acc_ok      <= acc_ok;
            o_acc_ind     <= (new_cyc && loc_ok) ? ind_of(w_loc) : `LDA_RST_IND;
            o_hash_start  <= hs;
            o_hash_data   <= hd;
            o_hash_end    <= he;
            o_hash_byte   <= hd ? l_word[7:0] : o_hash_byte;
            o_chk_done    <= i_chk_valid;
            o_chk_ok      <= next_chk_ok;
        end
    end

    sequence s_begin_free;
        st == lda_pkg::ST_FREE && new_cyc && cmd == lda_pkg::CMD_BEGIN;
    endsequence

    sequence s_hash_end;
        st == lda_pkg::ST_HASH && new_cyc && cmd == lda_pkg::CMD_END;
    endsequence

    chk_loc_decode: assert property (@(posedge i_clk) disable iff (i_rst)
        new_cyc && w_nib == 4'h2 |=> o_acc_valid && o_acc_ind == 5'h04)
        else $error("locality 2 not decoded");
    chk_ind_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
        (st == lda_pkg::ST_OWNED) == $onehot(o_active_ind) || st == lda_pkg::ST_HASH)
        else $error("owner indicator not one-hot");
    chk_seize_high: assert property (@(posedge i_clk) disable iff (i_rst)
        st == lda_pkg::ST_OWNED && !new_cyc && seize_eff == 5'h18 |=> o_active_ind == 5'h10)
        else $error("seize did not pick highest");
    chk_free_accept: assert property (@(posedge i_clk) disable iff (i_rst)
        st == lda_pkg::ST_FREE && new_cyc && hash_path |=> o_acc_ok)
        else $error("hash write refused in free state");
    chk_begin_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
        st == lda_pkg::ST_OWNED && owner != 3'h4 && new_cyc && cmd == lda_pkg::CMD_BEGIN
        |=> $stable(o_active_ind) && !o_hash_start && !o_hash_active)
        else $error("hash begin taken under other owner");
    chk_begin_take: assert property (@(posedge i_clk) disable iff (i_rst)
        s_begin_free |=> o_active_ind == 5'h10 && o_hash_start ##1 !o_hash_start && o_hash_active)
        else $error("hash begin did not take locality 4");
    chk_end_free: assert property (@(posedge i_clk) disable iff (i_rst)
        s_hash_end |=> o_hash_end && o_active_ind == 5'h00 && !o_hash_active)
        else $error("hash end did not free the owner");
    chk_hash_filter: assert property (@(posedge i_clk) disable iff (i_rst)
        st == lda_pkg::ST_HASH && new_cyc && !hash_path |=> o_acc_valid && !o_acc_ok)
        else $error("foreign cycle passed during hash");
    chk_res_check: assert property (@(posedge i_clk) disable iff (i_rst)
        i_chk_valid && (i_chk_mask & cmd_ind) == 5'h00 |=> o_chk_done && !o_chk_ok)
        else $error("resource locality mismatch accepted");
    chk_reset_free: assert property (@(posedge i_clk)
        $fell(i_rst) |-> o_active_ind == 5'h00 && !o_hash_active && !o_acc_valid)
        else $error("owner held after reset");

endmodule
`default_nettype wire

/* verif/lda_host_model.sv */
// Purpose: host bus controller that offers byte cycles on the link
// Assumes: link clock runs free, one cycle in flight at a time
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module lda_host_model
(
    // link side
    input  wire logic        i_link_clk,
    input  wire logic        i_link_wait,
    output var  logic        o_cyc_valid,
    output var  logic        o_cyc_write,
    output var  logic [15:0] o_cyc_addr,
    output var  logic [7:0]  o_cyc_data
);
    localparam logic [63:0] SYS_BASE = 64'h0000_0000_FED4_0000;
    localparam logic [7:0]  SPI_TOP  = 8'hD4;
    initial
    begin
        o_cyc_valid = 1'b0;
        o_cyc_write = 1'b0;
        o_cyc_addr  = 16'h0000;
        o_cyc_data  = 8'h00;
    end
    // locality-4 offsets come only from the bench's launch sequences
    task automatic cycle(input logic [15:0] off, input logic [7:0] d, input logic wr, output logic fin);
        logic [63:0] sys;
        logic [23:0] spi;
        sys = SYS_BASE | {48'h0, off};
        spi = {SPI_TOP, sys[15:0]};
        fin = 1'b0;
        @(posedge i_link_clk);
        o_cyc_valid <= 1'b1;
        o_cyc_write <= wr;
        o_cyc_addr  <= spi[15:0];
        o_cyc_data  <= d;
        @(posedge i_link_clk);
        o_cyc_valid <= 1'b0;
        o_cyc_write <= ~wr;
        o_cyc_addr  <= ~spi[15:0];
        o_cyc_data  <= ~d;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge i_link_clk);
            if (i_link_wait === 1'b0)
            begin
                fin = 1'b1;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

/* verif/test_locality_decode_arbiter.sv */
// Purpose: self-checking bench for the locality decoder and arbiter
// Assumes: host cycles come from the partner model on an 80 ns link clock
// Notes:   acceptance and hash pulses are counted as they occur
`timescale 1ns/1ns
`default_nettype none
module test_locality_decode_arbiter;
    logic        i_clk, i_rst, i_link_clk, i_buffer_map, i_relinquish, i_chk_valid;
    logic [4:0]  i_req, i_seize, i_chk_mask;
    logic        i_cyc_valid, i_cyc_write, o_link_wait, o_chk_done, o_chk_ok, o_hash_active;
    logic [15:0] i_cyc_addr;
    logic [7:0]  i_cyc_data, o_hash_byte;
    logic        o_acc_valid, o_acc_ok, o_hash_start, o_hash_data, o_hash_end, last_ok;
    logic [4:0]  o_active_ind, o_acc_ind, last_ind;
    int          err_count, checks, na, ns, nd, ne;

    lda_arbiter i_lda_arbiter (.i_clk, .i_rst, .i_link_clk, .i_cyc_valid, .i_cyc_write, .i_cyc_addr,
        .i_cyc_data, .o_link_wait, .i_buffer_map, .i_req, .i_seize, .i_relinquish, .i_chk_valid,
        .i_chk_mask, .o_chk_done, .o_chk_ok, .o_active_ind, .o_hash_active, .o_acc_valid, .o_acc_ok,
        .o_acc_ind, .o_hash_start, .o_hash_data, .o_hash_end, .o_hash_byte);
    lda_host_model i_lda_host_model (.i_link_clk, .i_link_wait(o_link_wait), .o_cyc_valid(i_cyc_valid),
        .o_cyc_write(i_cyc_write), .o_cyc_addr(i_cyc_addr), .o_cyc_data(i_cyc_data));

    always #5 i_clk = ~i_clk;
    // odd offset keeps the two clocks out of step
    always
    begin
        #37;
        i_link_clk = ~i_link_clk;
        #3;
    end
    always @(posedge i_clk)
    begin
        if (o_acc_valid === 1'b1)
        begin
            na++;
            last_ok = o_acc_ok;
            last_ind = o_acc_ind;
        end
        if (o_hash_start === 1'b1) ns++;
        if (o_hash_data === 1'b1) nd++;
        if (o_hash_end === 1'b1) ne++;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one host cycle; ev holds the start, data and end pulses expected
    task automatic host(input logic [15:0] off, input logic [7:0] d, input logic wr, input logic ok,
                        input logic [4:0] ind, input logic [2:0] ev);
        int a0, s0, d0, e0;
        logic fin;
        a0 = na;
        s0 = ns;
        d0 = nd;
        e0 = ne;
        i_lda_host_model.cycle(off, d, wr, fin);
        if (fin !== 1'b1)
        begin
            err_count++;
            end_of_test();
        end
        else
        begin
            check(16'(na - a0), 16'h0001);
            check({15'h0, last_ok}, {15'h0, ok});
            check({11'h0, last_ind}, {11'h0, ind});
            check({13'h0, ns != s0, nd != d0, ne != e0}, {13'h0, ev});
        end
    endtask
    task automatic core(input logic [4:0] req, input logic [4:0] sz, input logic rel, input logic [4:0] exp);
        @(posedge i_clk);
        i_req <= req;
        i_seize <= sz;
        i_relinquish <= rel;
        @(posedge i_clk);
        i_seize <= 5'h00;
        i_relinquish <= 1'b0;
        @(posedge i_clk);
        #1;
        check({11'h0, o_active_ind}, {11'h0, exp});
    endtask
    task automatic chk(input logic [4:0] m, input logic exp);
        int n;
        @(posedge i_clk);
        i_chk_mask <= m;
        i_chk_valid <= 1'b1;
        for (n = 0; n < 4; n++)
        begin
            @(posedge i_clk);
            i_chk_valid <= 1'b0;
            #1;
            if (o_chk_done === 1'b1) break;
        end
        if (n == 4)
        begin
            err_count++;
            end_of_test();
        end
        else
        begin
            check({15'h0, o_chk_ok}, {15'h0, exp});
        end
    endtask

    task automatic t_decode();
        for (int n = 0; n < 6; n++)
            host({n[3:0], 12'h000}, 8'h00, 1'b0, 1'b0, (n < 5) ? 5'(1 << n) : 5'h00, 3'h0);
        $display("decode done");
    endtask
    task automatic t_arbitrate();
        core(5'h05, 5'h00, 1'b0, 5'h04);
        core(5'h03, 5'h00, 1'b1, 5'h02);
        core(5'h00, 5'h08, 1'b0, 5'h08);
        core(5'h00, 5'h00, 1'b1, 5'h00);
        core(5'h04, 5'h00, 1'b0, 5'h04);
        // two seizers above owner 2: locality 4 must win
        core(5'h04, 5'h18, 1'b0, 5'h10);
        // owner 4 gives up while locality 2 still requests
        core(5'h04, 5'h00, 1'b1, 5'h04);
        core(5'h00, 5'h00, 1'b0, 5'h04);
        host(16'h2000, 8'h00, 1'b0, 1'b1, 5'h04, 3'h0);
        host(16'h1000, 8'h00, 1'b0, 1'b0, 5'h02, 3'h0);
        chk(5'h04, 1'b1);
        chk(5'h0B, 1'b0);
        host(16'h4028, 8'h00, 1'b1, 1'b0, 5'h10, 3'h0);
        check({11'h0, o_active_ind}, 16'h0004);
        core(5'h00, 5'h00, 1'b1, 5'h00);
        $display("arbitrate done");
    endtask
    task automatic t_hash_fifo();
        host(16'h4028, 8'h00, 1'b1, 1'b1, 5'h10, 3'h4);
        check({15'h0, o_hash_active}, 16'h0001);
        check({11'h0, o_active_ind}, 16'h0010);
        core(5'h08, 5'h00, 1'b0, 5'h10);
        core(5'h00, 5'h00, 1'b0, 5'h10);
        host(16'h3000, 8'h11, 1'b1, 1'b0, 5'h08, 3'h0);
        host(16'h4028, 8'h00, 1'b1, 1'b0, 5'h10, 3'h0);
        host(16'h4024, 8'hA5, 1'b1, 1'b1, 5'h10, 3'h2);
        check({8'h0, o_hash_byte}, 16'h00A5);
        host(16'h4020, 8'h00, 1'b1, 1'b1, 5'h10, 3'h1);
        check({10'h0, o_hash_active, o_active_ind}, 16'h0000);
        $display("hash fifo done");
    endtask
    task automatic t_hash_buf();
        @(posedge i_clk);
        i_buffer_map <= 1'b1;
        host(16'h4008, 8'h01, 1'b1, 1'b1, 5'h10, 3'h4);
        host(16'h4080, 8'h3C, 1'b1, 1'b1, 5'h10, 3'h2);
        check({8'h0, o_hash_byte}, 16'h003C);
        host(16'h4008, 8'h02, 1'b1, 1'b1, 5'h10, 3'h1);
        check({10'h0, o_hash_active, o_active_ind}, 16'h0000);
        $display("hash buffer done");
    endtask

    initial
    begin
        i_clk = 1'b0;
        i_link_clk = 1'b0;
        i_rst = 1'b1;
        i_buffer_map = 1'b0;
        i_req = 5'h00;
        i_seize = 5'h00;
        i_relinquish = 1'b0;
        i_chk_valid = 1'b0;
        i_chk_mask = 5'h00;
        repeat (6) @(posedge i_clk);
        // the slow link needs its own edges before release
        repeat (2) @(posedge i_link_clk);
        @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        check({10'h0, o_hash_active, o_active_ind}, 16'h0000);
        t_decode();
        t_arbitrate();
        t_hash_fifo();
        t_hash_buf();
        end_of_test();
    end
endmodule
`default_nettype wire
